// ### logic/sabs_defs.svh
`ifndef SABS_DEFS_SVH
`define SABS_DEFS_SVH

// =============================================================================
// Widths and timing counts
// =============================================================================
`define SABS_ADDR_W        24
`define SABS_DATA_W        8
`define SABS_STATE_CNT_W   4
// Cycles per bus-mode state after reset; legal range is 2 to 15.
`define SABS_CLKS_PER_STATE_RST 4'h2
`define SABS_CLKS_PER_STATE_MIN 4'h2
// Bus mode codes on the request port.
`define SABS_MODE_W        2
`define SABS_MODE_NATIVE   2'h0
`define SABS_MODE_STROBE   2'h3

`endif

// ### logic/sabs_pkg.sv
`default_nettype none
package sabs_pkg;
    typedef enum logic [3:0] {
        sabs_idle   = 4'b0000,
        sabs_switch = 4'b0001,
        sabs_s0     = 4'b0010,
        sabs_s1     = 4'b0011,
        sabs_s2     = 4'b0100,
        sabs_s3     = 4'b0101,
        sabs_s4     = 4'b0110,
        sabs_wait   = 4'b0111,
        sabs_s5     = 4'b1000,
        sabs_s6     = 4'b1001,
        sabs_s7     = 4'b1010
    } sabs_state_type;
endpackage
`default_nettype wire

// ### logic/sabs_state_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "sabs_defs.svh"

// =============================================================================
// State timer: one-cycle pulse at the end of each bus-mode state
// =============================================================================
module sabs_state_timer (
    // Clock and reset
    input  wire logic                           clock,
    input  wire logic                           rstn,
    // Control
    input  wire logic                           restart,
    input  wire logic [`SABS_STATE_CNT_W-1:0]   clks_per_state,
    // Status
    output logic                                state_done
);
    logic [`SABS_STATE_CNT_W-1:0] count;
    logic [`SABS_STATE_CNT_W-1:0] next_count;
    logic [`SABS_STATE_CNT_W-1:0] length;

    // Values below two are clamped so every state lasts at least two cycles.
    always_comb begin
        length = (clks_per_state < `SABS_CLKS_PER_STATE_MIN) ? `SABS_CLKS_PER_STATE_MIN : clks_per_state;
        if (restart || state_done) begin
            next_count = 4'h1;
        end else begin
            next_count = count + 4'h1;
        end
    end

    assign state_done = (count == length) && !restart;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count <= 4'h1;
        end else begin
            count <= next_count;
        end
    end
endmodule // sabs_state_timer
`default_nettype wire

// ### logic/sabs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "sabs_defs.svh"

// =============================================================================
// Strobe-and-acknowledge bus sequencer
// =============================================================================
module sabs_sequencer (
    // Clock and reset
    input  wire logic                           clock,
    input  wire logic                           rstn,
    // Configuration
    input  wire logic [`SABS_STATE_CNT_W-1:0]   clks_per_state,
    input  wire logic [2:0]                     chip_select_wait_count,
    // Bus controller request side
    input  wire logic                           req_valid,
    input  wire logic                           req_write,
    input  wire logic [`SABS_ADDR_W-1:0]        req_addr,
    input  wire logic [`SABS_DATA_W-1:0]        req_wdata,
    input  wire logic [`SABS_MODE_W-1:0]        req_mode,
    input  wire logic [`SABS_MODE_W-1:0]        prev_mode,
    output logic                                req_ready,
    output logic                                done,
    output logic [`SABS_DATA_W-1:0]             rdata,
    // External bus
    output logic [`SABS_ADDR_W-1:0]             addr,
    output logic                                read_not_write,
    output logic                                addr_valid_strobe_n,
    output logic                                data_strobe_n,
    input  wire logic [`SABS_DATA_W-1:0]        data_in,
    output logic [`SABS_DATA_W-1:0]             data_out,
    output logic                                data_oe,
    input  wire logic                           transfer_ack_n
);
    sabs_pkg::sabs_state_type state;
    sabs_pkg::sabs_state_type next_state;
    logic                       is_write;
    logic                       next_is_write;
    logic [`SABS_ADDR_W-1:0]    lat_addr;
    logic [`SABS_ADDR_W-1:0]    next_lat_addr;
    logic [`SABS_DATA_W-1:0]    lat_wdata;
    logic [`SABS_DATA_W-1:0]    next_lat_wdata;
    logic                       ack_seen;
    logic                       next_ack_seen;
    logic                       next_req_ready;
    logic                       next_done;
    logic [`SABS_DATA_W-1:0]    next_rdata;
    logic [`SABS_ADDR_W-1:0]    next_addr;
    logic                       next_read_not_write;
    logic                       next_addr_valid_strobe_n;
    logic                       next_data_strobe_n;
    logic [`SABS_DATA_W-1:0]    next_data_out;
    logic                       next_data_oe;
    logic                       state_done;
    logic                       timer_restart;
    logic                       needs_switch;
    logic [2:0]                 unused_wait;

    // The programmed wait count has no effect in this mode.
    assign unused_wait = chip_select_wait_count;

    // =========================================================================
    // State timer
    // =========================================================================
    // The timer restarts whenever a transfer begins so S0 is a full state.
    assign timer_restart = (state == sabs_pkg::sabs_idle) || (state == sabs_pkg::sabs_switch);

    sabs_state_timer u_timer (
        .clock          (clock),
        .rstn           (rstn),
        .restart        (timer_restart),
        .clks_per_state (clks_per_state),
        .state_done     (state_done)
    );

    // One extra cycle whenever the previous transfer used any other mode, native included.
    // Back-to-back transfers in this mode take none; a move into native mode never passes here.
    assign needs_switch = (prev_mode != req_mode);

    // =========================================================================
    // Next-state and output logic
    // =========================================================================
    always_comb begin
        next_state               = state;
        next_is_write            = is_write;
        next_lat_addr            = lat_addr;
        next_lat_wdata           = lat_wdata;
        next_ack_seen            = ack_seen;
        next_req_ready           = 1'b0;
        next_done                = 1'b0;
        next_rdata               = rdata;
        next_addr                = addr;
        next_read_not_write      = read_not_write;
        next_addr_valid_strobe_n = addr_valid_strobe_n;
        next_data_strobe_n       = data_strobe_n;
        next_data_out            = data_out;
        next_data_oe             = data_oe;
        case (state)
            sabs_pkg::sabs_idle: begin
                next_req_ready = 1'b1;
                if (req_valid && req_ready && req_mode == `SABS_MODE_STROBE) begin
                    next_req_ready = 1'b0;
                    next_is_write  = req_write;
                    next_lat_addr  = req_addr;
                    next_lat_wdata = req_wdata;
                    next_ack_seen  = 1'b0;
                    // Direction high in S0 for reads and after any earlier write.
                    next_read_not_write = 1'b1;
                    next_state = needs_switch ? sabs_pkg::sabs_switch : sabs_pkg::sabs_s0;
                end
            end
            sabs_pkg::sabs_switch: begin
                next_state = sabs_pkg::sabs_s0;
            end
            sabs_pkg::sabs_s0: begin
                next_read_not_write = 1'b1;
                if (state_done) begin
                    next_addr  = lat_addr;
                    next_state = sabs_pkg::sabs_s1;
                end
            end
            sabs_pkg::sabs_s1: begin
                if (state_done) begin
                    next_addr_valid_strobe_n = 1'b0;
                    if (is_write) begin
                        next_read_not_write = 1'b0;
                    end else begin
                        next_data_strobe_n = 1'b0;
                    end
                    next_state = sabs_pkg::sabs_s2;
                end
            end
            sabs_pkg::sabs_s2: begin
                if (state_done) begin
                    if (is_write) begin
                        next_data_out = lat_wdata;
                        next_data_oe  = 1'b1;
                    end
                    next_state = sabs_pkg::sabs_s3;
                end
            end
            sabs_pkg::sabs_s3: begin
                // Outputs hold through S3.
                if (state_done) begin
                    if (is_write) begin
                        next_data_strobe_n = 1'b0;
                    end
                    next_ack_seen = 1'b0;
                    next_state    = sabs_pkg::sabs_s4;
                end
            end
            sabs_pkg::sabs_s4, sabs_pkg::sabs_wait: begin
                // The acknowledge must be seen one full clock before the state ends;
                // the sample on the final edge itself does not count.
                if (!state_done && !transfer_ack_n) begin
                    next_ack_seen = 1'b1;
                end
                if (state_done) begin
                    if (ack_seen) begin
                        next_state = sabs_pkg::sabs_s5;
                    end else begin
                        next_state = sabs_pkg::sabs_wait;
                    end
                end
            end
            sabs_pkg::sabs_s5: begin
                // No output moves here for reads or writes.
                if (state_done) begin
                    next_state = sabs_pkg::sabs_s6;
                end
            end
            sabs_pkg::sabs_s6: begin
                // Read data is driven by the peripheral in this state.
                if (state_done) begin
                    if (!is_write) begin
                        next_rdata = data_in;
                    end
                    // Strobe release also tells the peripheral to drop its acknowledge.
                    next_addr_valid_strobe_n = 1'b1;
                    next_data_strobe_n       = 1'b1;
                    next_state               = sabs_pkg::sabs_s7;
                end
            end
            sabs_pkg::sabs_s7: begin
                if (state_done) begin
                    next_read_not_write = 1'b1;
                    next_data_oe        = 1'b0;
                    next_done           = 1'b1;
                    next_req_ready      = 1'b1;
                    next_state          = sabs_pkg::sabs_idle;
                end
            end
            default: begin
                next_state = sabs_pkg::sabs_idle;
            end
        endcase
    end

    // =========================================================================
    // Registers
    // =========================================================================
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state               <= sabs_pkg::sabs_idle;
            is_write            <= 1'b0;
            lat_addr            <= 24'h00_0000;
            lat_wdata           <= 8'h00;
            ack_seen            <= 1'b0;
            req_ready           <= 1'b0;
            done                <= 1'b0;
            rdata               <= 8'h00;
            addr                <= 24'h00_0000;
            read_not_write      <= 1'b1;
            addr_valid_strobe_n <= 1'b1;
            data_strobe_n       <= 1'b1;
            data_out            <= 8'h00;
            data_oe             <= 1'b0;
        end else begin
            state               <= next_state;
            is_write            <= next_is_write;
            lat_addr            <= next_lat_addr;
            lat_wdata           <= next_lat_wdata;
            ack_seen            <= next_ack_seen;
            req_ready           <= next_req_ready;
            done                <= next_done;
            rdata               <= next_rdata;
            addr                <= next_addr;
            read_not_write      <= next_read_not_write;
            addr_valid_strobe_n <= next_addr_valid_strobe_n;
            data_strobe_n       <= next_data_strobe_n;
            data_out            <= next_data_out;
            data_oe             <= next_data_oe;
        end
    end
endmodule // sabs_sequencer
`default_nettype wire

// ### dv/sabs_seq_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "sabs_defs.svh"
// ============================================================
// Bus timing checker.
module sabs_seq_chk (
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      rstn,
    // Controller side
    input  wire logic                      req_valid,
    input  wire logic [`SABS_MODE_W-1:0]   req_mode,
    input  wire logic                      req_ready,
    input  wire logic                      done,
    // External bus
    input  wire logic [`SABS_ADDR_W-1:0]   addr,
    input  wire logic                      read_not_write,
    input  wire logic                      addr_valid_strobe_n,
    input  wire logic                      data_strobe_n,
    input  wire logic [`SABS_DATA_W-1:0]   data_out,
    input  wire logic                      data_oe,
    input  wire logic                      transfer_ack_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    read_strobes_a: assert property ($fell(data_strobe_n) && read_not_write |-> $fell(addr_valid_strobe_n))
        else $error("read strobes not asserted together");
    write_rnw_low_a: assert property ($fell(addr_valid_strobe_n) && !read_not_write |-> $fell(read_not_write) && data_strobe_n)
        else $error("write direction not lowered with address strobe");
    write_ds_late_a: assert property ($fell(data_strobe_n) && !read_not_write |-> $past(data_oe) && !$past(addr_valid_strobe_n, 2))
        else $error("write data strobe too early");
    addr_ready_a: assert property ($fell(addr_valid_strobe_n) |-> $stable(addr))
        else $error("address changed with strobe");
    strobes_end_a: assert property ($rose(addr_valid_strobe_n) |-> $rose(data_strobe_n) && !$past(transfer_ack_n))
        else $error("strobes released apart or without acknowledge");
    bus_hold_a: assert property (!addr_valid_strobe_n && !$past(addr_valid_strobe_n) |-> $stable(addr) && $stable(read_not_write))
        else $error("bus output changed inside transfer");
    wdata_hold_a: assert property (data_oe && $past(data_oe) |-> $stable(data_out) && !read_not_write)
        else $error("write data not held");
    s7_done_a: assert property ($rose(addr_valid_strobe_n) |-> ##[2:15] done)
        else $error("no completion after strobes released");
    end_state_a: assert property (done |-> read_not_write && !data_oe && req_ready)
        else $error("bus not returned to rest at completion");
    take_ready_a: assert property (req_valid && req_ready && req_mode == `SABS_MODE_STROBE |=> !req_ready)
        else $error("ready held after take");
    idle_quiet_a: assert property (req_ready |-> addr_valid_strobe_n && data_strobe_n)
        else $error("strobe active while idle");
endmodule // sabs_seq_chk
`default_nettype wire

// ### dv/sabs_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Far-side peripheral with a programmable acknowledge delay.
module sabs_periph_model (
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          rstn,
    // Bus from the sequencer
    input  wire logic [23:0]   addr,
    input  wire logic          read_not_write,
    input  wire logic          data_strobe_n,
    input  wire logic [7:0]    data_out,
    input  wire logic          data_oe,
    // Bench control
    input  wire logic [3:0]    ack_delay,
    // Answers
    output logic [7:0]         data_in,
    output logic               transfer_ack_n
);
    logic [7:0] mem [16];
    logic [3:0] cnt;
    logic [7:0] junk;
    // Acknowledge drops once the strobe is gone, so a stale low never starts the next transfer.
    assign transfer_ack_n = data_strobe_n | (cnt < ack_delay);
    // Outside its drive window the bus shows a changing pattern, never the last value.
    assign data_in = (!transfer_ack_n && read_not_write) ? mem[addr[3:0]] : junk;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt  <= 4'h0;
            junk <= 8'h5a;
        end else begin
            junk <= junk + 8'h3b;
            cnt  <= data_strobe_n ? 4'h0 : (cnt == 4'hf ? cnt : cnt + 4'h1);
            if (!transfer_ack_n && data_oe) begin
                mem[addr[3:0]] <= data_out;
            end
        end
    end
endmodule // sabs_periph_model
`default_nettype wire

// ### dv/strobe_ack_bus_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Bench top.
module strobe_ack_bus_sequencer_tb;
    typedef struct {logic w; logic [23:0] a; logic [7:0] wd; logic [1:0] pm; logic [3:0] d, n; logic [2:0] cw;} sabs_row_type;
    logic        clock = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic [3:0]  clks_per_state = 4'h2, ack_delay = 4'h0;
    logic [2:0]  chip_select_wait_count = 3'h0;
    logic [23:0] req_addr = 24'h00_0000, addr;
    logic [7:0]  req_wdata = 8'h00, rdata, data_in, data_out;
    logic [1:0]  req_mode = 2'h3, prev_mode = 2'h0;
    logic        req_ready, done, read_not_write, addr_valid_strobe_n, data_strobe_n, data_oe, transfer_ack_n;
    logic [7:0]  shadow [16];
    int          errors = 0, check_count = 0, cycles = 0, lat;
    sabs_row_type rows [8] = '{
        '{1'b1, 24'h12_3450, 8'ha5, 2'h0, 4'h0, 4'h2, 3'h0}, '{1'b0, 24'h12_3450, 8'h00, 2'h3, 4'h0, 4'h2, 3'h7},
        '{1'b1, 24'hff_fff1, 8'h5a, 2'h1, 4'h1, 4'h2, 3'h3}, '{1'b1, 24'h00_0002, 8'h3c, 2'h3, 4'h4, 4'h3, 3'h1},
        '{1'b0, 24'hff_fff1, 8'h00, 2'h2, 4'h5, 4'h2, 3'h2}, '{1'b0, 24'h00_0002, 8'h00, 2'h0, 4'h9, 4'h3, 3'h5},
        '{1'b1, 24'h80_0003, 8'hc3, 2'h0, 4'h0, 4'hf, 3'h0}, '{1'b0, 24'h80_0003, 8'h00, 2'h3, 4'h0, 4'h1, 3'h4}};
    always #5 clock = ~clock;
    sabs_sequencer i_dut (.clock, .rstn, .clks_per_state, .chip_select_wait_count, .req_valid, .req_write,
        .req_addr, .req_wdata, .req_mode, .prev_mode, .req_ready, .done, .rdata, .addr, .read_not_write,
        .addr_valid_strobe_n, .data_strobe_n, .data_in, .data_out, .data_oe, .transfer_ack_n);
    sabs_periph_model i_peer (.clock, .rstn, .addr, .read_not_write, .data_strobe_n, .data_out, .data_oe,
        .ack_delay, .data_in, .transfer_ack_n);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Cycles from the take edge to the completion pulse; waits use the partner's acknowledge delay.
    function automatic int exp_lat(input sabs_row_type r);
        int ne, base, k;
        ne = (r.n < 2) ? 2 : int'(r.n);
        base = r.w ? ne - 2 : 3 * ne - 2;
        k = (int'(r.d) > base) ? (int'(r.d) - base + ne - 1) / ne : 0;
        return 8 * ne + k * ne + ((r.pm != 2'h3) ? 1 : 0);
    endfunction
    task automatic run(input sabs_row_type r, output int n);
        @(negedge clock);
        {req_write, req_addr, req_wdata, prev_mode} = {r.w, r.a, r.wd, r.pm};
        {ack_delay, clks_per_state, chip_select_wait_count} = {r.d, r.n, r.cw};
        req_valid = 1'b1;
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
        req_valid = 1'b0;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (done !== 1'b1 && n < 400);
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        repeat (12) @(negedge clock);
        chk({req_ready, addr_valid_strobe_n, data_strobe_n, read_not_write, data_oe, addr}, {5'b01110, 24'h00_0000});
        rstn = 1'b1;
        @(negedge clock);
        chk(req_ready, 1'b1);
        for (int i = 0; i < 8; i++) begin
            run(rows[i], lat);
            chk(lat, exp_lat(rows[i]));
            if (rows[i].w) begin
                shadow[rows[i].a[3:0]] = rows[i].wd;
            end else begin
                chk(rdata, shadow[rows[i].a[3:0]]);
            end
        end
        // A request in another bus mode must be left alone.
        @(negedge clock);
        {req_mode, req_valid} = {2'h1, 1'b1};
        repeat (20) @(negedge clock);
        chk({req_ready, addr_valid_strobe_n, data_strobe_n}, 3'b111);
        {req_mode, req_valid, req_write} = {2'h3, 1'b1, 1'b1};
        @(negedge clock);
        req_valid = 1'b0;
        lat = 0;
        while (addr_valid_strobe_n !== 1'b0 && lat < 50) begin
            @(negedge clock);
            lat++;
        end
        rstn = 1'b0;
        @(negedge clock);
        chk({addr_valid_strobe_n, data_strobe_n, read_not_write, data_oe}, 4'b1110);
        rstn = 1'b1;
        run(rows[1], lat);
        chk(lat, exp_lat(rows[1]));
        chk(rdata, 8'ha5);
        summarize();
    end
endmodule // strobe_ack_bus_sequencer_tb
bind sabs_sequencer sabs_seq_chk i_chk (.clock, .rstn, .req_valid, .req_mode, .req_ready, .done, .addr,
    .read_not_write, .addr_valid_strobe_n, .data_strobe_n, .data_out, .data_oe, .transfer_ack_n);
`default_nettype wire
